// ---- sscw_defines.vh ----
// How it works
// - status bit0 shows motor enabled; bit1 set only when every means grants enable
// - status bit2 shows inching active; bit3 set only during initial pre-start tests
// - status bit4 high for whole acceleration ramp; bit7 for whole deceleration
// - status bit5 shows full voltage applied; bit6 shows bypass closed
// - status bit8 is 0 local, 1 remote; bit9 high while braking runs
// - status bit10 high during rotation reversal; bit11 is 0 forward, 1 reverse
// - status bit12 high during pre-start delay; bit13 during post-stop delay
// - status bit14 high on any alarm; bit15 high on any fault
// - command bit0 start/stop ramp, bit1 general enable, bit2 inching
// - command bit3 selects rotation direction; bit4 selects local or remote mode
// - command bit7 resets a fault only on rising edge with fault active
// - only input-pins word carries bit8 braking and bit9 emergency start
// - a separate command word is kept for each of six sources
// - start/stop and inching bits of inactive sources are cleared
// - inactive sources show no commands; active source shows its commands
// - heatsink temperature reported in signed degrees, -22 to 260
// - motor thermal image reported 0.0 to 100.0 percent, tenths
// - six motor temperature channels reported in signed degrees, -20 to 260
`ifndef SSCW_DEFINES_VH
`define SSCW_DEFINES_VH
// register byte offsets
`define SSCW_OFF_STATUS     12'h000
`define SSCW_OFF_CMD_BASE   12'h004
`define SSCW_OFF_ACTIVE_SRC 12'h01c
`define SSCW_OFF_HEATSINK   12'h020
`define SSCW_OFF_THERMAL    12'h024
`define SSCW_OFF_MOTOR_BASE 12'h028
`define SSCW_OFF_IRQ_STAT   12'h040
`define SSCW_OFF_IRQ_MASK   12'h044
`define SSCW_OFF_WRITE_CMD  12'h048
// command word fields
`define SSCW_CMD_START      0
`define SSCW_CMD_ENABLE     1
`define SSCW_CMD_INCH       2
`define SSCW_CMD_DIR        3
`define SSCW_CMD_REMOTE     4
`define SSCW_CMD_RESET      7
`define SSCW_CMD_BRAKE      8
`define SSCW_CMD_EMERG      9
// writable masks: pins word keeps bits 0-4,7-9; others 0-4,7
`define SSCW_MASK_PINS      16'h039f
`define SSCW_MASK_OTHER     16'h009f
// interrupt bits
`define SSCW_IRQ_FAULT_RST  0
`define SSCW_IRQ_FAULT      1
`define SSCW_IRQ_ALARM      2
// reset values
`define SSCW_RST_ACTIVE_SRC 3'h0
`define SSCW_RST_MASK       3'h0
// temperature ranges
`define SSCW_HS_MIN         -22
`define SSCW_HS_MAX         260
`define SSCW_MT_MIN         -20
`define SSCW_MT_MAX         260
`define SSCW_TI_MAX         1000
`endif

// ---- sscw_sync.v ----
`timescale 1ns/1ps
// three-stage synchroniser; output changes once stages two and three agree
module sscw_sync #(
   parameter W = 16
) (
   // clock and reset
   input  wire         pclk,
   input  wire         presetn,
   input  wire         clk_en,
   // data
   input  wire [W-1:0] d_in,
   output reg  [W-1:0] q_out
);
   reg [W-1:0] s1_reg;
   reg [W-1:0] s2_reg;
   reg [W-1:0] s3_reg;

   // first stage feeds only the second; agreement filters a single glitch
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_reg <= {W{1'b0}};
         s2_reg <= {W{1'b0}};
         s3_reg <= {W{1'b0}};
         q_out  <= {W{1'b0}};
      end else if (clk_en) begin
         s1_reg <= d_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         q_out  <= (s2_reg & s3_reg) | (q_out & (s2_reg | s3_reg));
      end
   end
endmodule // sscw_sync

// ---- sscw_top.v ----
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "sscw_defines.vh"
module sscw_top (
   // apb slave
   input  wire        pclk,
   input  wire        presetn,
   input  wire        clk_en,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // drive state from the motor controller (asynchronous)
   input  wire        st_running,
   input  wire        st_all_enables,
   input  wire        st_inching,
   input  wire        st_initial_test,
   input  wire        st_ramp_up,
   input  wire        st_full_voltage,
   input  wire        st_bypass_closed,
   input  wire        st_ramp_down,
   input  wire        st_braking,
   input  wire        st_reversing,
   input  wire        st_reverse,
   input  wire        st_delay_before,
   input  wire        st_delay_after,
   input  wire        st_alarm,
   input  wire        st_fault,
   // raw digital input command word
   input  wire [15:0] input_pins_command_word,
   // measurements, already scaled
   input  wire [15:0] heatsink_temperature,
   input  wire [15:0] thermal_image,
   input  wire [95:0] motor_temperature,
   input  wire        sensor_fitted,
   // outputs to the motor controller
   output reg  [15:0] active_command,
   output reg         fault_reset,
   output reg         irq
);
   localparam NSRC = 6;

   // pin-level status bits pass the synchroniser
   wire [14:0] st_raw = {st_alarm, st_delay_after, st_delay_before,
                         st_reverse, st_reversing, st_braking,
                         st_ramp_down, st_bypass_closed, st_full_voltage,
                         st_ramp_up, st_initial_test, st_inching,
                         st_all_enables, st_running, st_fault};
   wire [14:0] st_sync;
   wire [15:0] pins_sync;

   sscw_sync #(.W(15)) u_st_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .clk_en  (clk_en),
      .d_in    (st_raw),
      .q_out   (st_sync)
   );

   sscw_sync #(.W(16)) u_pin_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .clk_en  (clk_en),
      .d_in    (input_pins_command_word),
      .q_out   (pins_sync)
   );

   wire fault_now = st_sync[0];
   wire alarm_now = st_sync[14];

   // status word assembly: bit n follows its state input; bit 8 follows the active command's remote bit
   wire [15:0] status_word;
   assign status_word[0]  = st_sync[1];
   assign status_word[1]  = st_sync[2];
   assign status_word[2]  = st_sync[3];
   assign status_word[3]  = st_sync[4];
   assign status_word[4]  = st_sync[5];
   assign status_word[5]  = st_sync[6];
   assign status_word[6]  = st_sync[7];
   assign status_word[7]  = st_sync[8];
   assign status_word[8]  = active_command[`SSCW_CMD_REMOTE];
   assign status_word[9]  = st_sync[9];
   assign status_word[10] = st_sync[10];
   assign status_word[11] = st_sync[11];
   assign status_word[12] = st_sync[12];
   assign status_word[13] = st_sync[13];
   assign status_word[14] = alarm_now;
   assign status_word[15] = fault_now;

   // registered state
   reg [15:0] status_reg;
   reg [15:0] cmd_reg [0:NSRC-1];
   reg [2:0]  active_src_reg;
   reg [2:0]  irq_stat_reg;
   reg [2:0]  irq_mask_reg;
   reg [15:0] hs_reg;
   reg [15:0] ti_reg;
   reg [95:0] mt_reg;
   reg        prev_reset_reg;
   reg        prev_alarm_reg;
   reg        prev_fault_reg;

   // apb decode; writes land in the single access cycle
   wire        acc    = psel & penable;
   wire        wr_acc = acc & pwrite;
   wire        rd_acc = acc & ~pwrite;
   reg         map_hit;
   reg  [31:0] rd_next;
   reg  [2:0]  rd_idx;
   integer     k;

   // clamp helper for signed temperatures
   function [15:0] clamp;
      input [15:0] v;
      input integer lo;
      input integer hi;
      reg signed [15:0] s;
      begin
         s = v;
         if (s < lo)
            clamp = lo[15:0];
         else if (s > hi)
            clamp = hi[15:0];
         else
            clamp = v;
      end
   endfunction

   // read mux and address check
   always @* begin
      rd_next = 32'h0000_0000;
      map_hit = 1'b1;
      rd_idx  = 3'h0;
      if (paddr == `SSCW_OFF_STATUS) begin
         rd_next = {16'h0000, status_reg};
      end else if (paddr >= `SSCW_OFF_CMD_BASE &&
                   paddr < `SSCW_OFF_ACTIVE_SRC && paddr[1:0] == 2'b00) begin
         rd_idx  = paddr[4:2] - 3'h1;
         rd_next = {16'h0000, cmd_reg[rd_idx]};
      end else if (paddr == `SSCW_OFF_ACTIVE_SRC) begin
         rd_next = {29'h0, active_src_reg};
      end else if (paddr == `SSCW_OFF_HEATSINK) begin
         rd_next = {{16{hs_reg[15]}}, hs_reg};
      end else if (paddr == `SSCW_OFF_THERMAL) begin
         rd_next = {16'h0000, ti_reg};
      end else if (paddr >= `SSCW_OFF_MOTOR_BASE &&
                   paddr < `SSCW_OFF_IRQ_STAT && paddr[1:0] == 2'b00) begin
         rd_idx  = paddr[4:2] - 3'h2;
         rd_next = {{16{mt_reg[rd_idx*16+15]}},
                    mt_reg[rd_idx*16 +: 16]};
      end else if (paddr == `SSCW_OFF_IRQ_STAT) begin
         rd_next = {29'h0, irq_stat_reg};
      end else if (paddr == `SSCW_OFF_IRQ_MASK) begin
         rd_next = {29'h0, irq_mask_reg};
      end else if (paddr == `SSCW_OFF_WRITE_CMD) begin
         rd_next = 32'h0000_0000;
      end else begin
         map_hit = 1'b0;
      end
   end

   // source write target: a command write lands on the active source only
   // when that source is software-driven (pins word follows its pins)
   wire [15:0] sw_mask = `SSCW_MASK_OTHER;

   // edge of the reset bit in the active word
   wire reset_edge = active_command[`SSCW_CMD_RESET] & ~prev_reset_reg;
   wire ev_fault   = fault_now & ~prev_fault_reg;
   wire ev_alarm   = alarm_now & ~prev_alarm_reg;
   wire [2:0] ev   = {ev_alarm, ev_fault, reset_edge & fault_now};

   // main register process
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_reg     <= 16'h0000;
         for (k = 0; k < NSRC; k = k + 1)
            cmd_reg[k] <= 16'h0000;
         active_src_reg <= `SSCW_RST_ACTIVE_SRC;
         irq_stat_reg   <= 3'h0;
         irq_mask_reg   <= `SSCW_RST_MASK;
         hs_reg         <= 16'h0000;
         ti_reg         <= 16'h0000;
         mt_reg         <= 96'h0;
         prev_reset_reg <= 1'b0;
         prev_alarm_reg <= 1'b0;
         prev_fault_reg <= 1'b0;
         active_command <= 16'h0000;
         fault_reset    <= 1'b0;
         irq            <= 1'b0;
         prdata         <= 32'h0000_0000;
         pready         <= 1'b0;
         pslverr        <= 1'b0;
      end else if (clk_en) begin
         status_reg <= status_word;
         // digital input word: reserved bits dropped
         cmd_reg[0] <= pins_sync & `SSCW_MASK_PINS;
         // inactive sources lose start/stop and inching, and every command
         for (k = 1; k < NSRC; k = k + 1)
            if (k != active_src_reg)
               cmd_reg[k] <= 16'h0000;
         if (active_src_reg != 3'h0)
            cmd_reg[0] <= 16'h0000;
         active_command <= cmd_reg[active_src_reg];
         prev_reset_reg <= active_command[`SSCW_CMD_RESET];
         prev_alarm_reg <= alarm_now;
         prev_fault_reg <= fault_now;
         fault_reset    <= reset_edge & fault_now;
         hs_reg <= clamp(heatsink_temperature,
                         `SSCW_HS_MIN, `SSCW_HS_MAX);
         ti_reg <= (thermal_image > `SSCW_TI_MAX) ?
                   16'h03e8 : thermal_image;
         for (k = 0; k < NSRC; k = k + 1)
            mt_reg[k*16 +: 16] <= sensor_fitted ?
               clamp(motor_temperature[k*16 +: 16],
                     `SSCW_MT_MIN, `SSCW_MT_MAX) : 16'h0000;
         // apb: zero-wait answer in the access cycle
         pready  <= 1'b0;
         pslverr <= 1'b0;
         if (psel & ~penable) begin
            pready  <= 1'b1;
            pslverr <= ~map_hit;
            prdata  <= (pwrite | ~map_hit) ? 32'h0000_0000 : rd_next;
         end
         // sticky status: new events win over a write-one clear
         irq_stat_reg <= irq_stat_reg | ev;
         if (wr_acc & pready) begin
            if (paddr == `SSCW_OFF_ACTIVE_SRC) begin
               if (pwdata[2:0] < NSRC)
                  active_src_reg <= pwdata[2:0];
            end else if (paddr == `SSCW_OFF_IRQ_MASK) begin
               irq_mask_reg <= pwdata[2:0];
            end else if (paddr == `SSCW_OFF_IRQ_STAT) begin
               irq_stat_reg <= (irq_stat_reg & ~pwdata[2:0]) | ev;
            end else if (paddr == `SSCW_OFF_WRITE_CMD) begin
               // software sources only; pins word follows its pins
               if (active_src_reg != 3'h0)
                  cmd_reg[active_src_reg] <= pwdata[15:0] & sw_mask;
            end
         end
         irq <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   // rd_acc kept for readability of the access phase
   wire unused_rd = rd_acc;
endmodule // sscw_top

// ---- sscw_chk_asserts.sv ----
`timescale 1ns/1ps
module sscw_chk (
   // watched ports
   input wire        pclk,
   input wire        presetn,
   input wire        clk_en,
   input wire        psel,
   input wire        penable,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire [15:0] active_command,
   input wire        fault_reset
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // bus answers are wait-free single pulses
   ready_after_setup_a:
      assert property (psel && !penable && clk_en |=> pready)
      else $error("setup not answered");
   ready_pulse_a:
      assert property (pready |=> !pready) else $error("ready held");
   ready_cause_a:
      assert property (pready |-> $past(psel && !penable))
      else $error("ready without setup");
   err_with_ready_a:
      assert property (pslverr |-> pready) else $error("lone error");
   err_data_zero_a:
      assert property (pslverr |-> prdata == 32'h0)
      else $error("error carries data");
   // fault reset only on a fresh rise of the reset bit
   reset_pulse_a:
      assert property (fault_reset |=> !fault_reset)
      else $error("fault reset held");
   reset_on_rise_a:
      assert property (fault_reset |-> $past(active_command[7]) &&
         !$past(active_command[7], 2)) else $error("reset on level");
   reserved_bits_a:
      assert property (active_command[6:5] == 2'h0 &&
         active_command[15:10] == 6'h0) else $error("reserved bit set");
endmodule // sscw_chk

// ---- sscw_far_side.sv ----
`timescale 1ns/1ps
module sscw_far_side (
   // clock
   input  wire         pclk,
   // levels the bench asks for
   input  wire  [15:0] st_req,
   input  wire  [15:0] pins_req,
   // lines into the block
   output logic [15:0] st_lines,
   output logic [15:0] pins_lines
);
   // lines move just after an edge, never mid-cycle
   always @(posedge pclk) begin
      st_lines <= st_req;
      pins_lines <= pins_req;
   end
endmodule // sscw_far_side

// ---- tb_top.sv ----
`timescale 1ns/1ps
`include "sscw_defines.vh"
module tb_top;
   // bench state, all inputs but st_l and pins_l valued at time zero
   logic        pclk, pready, pslverr, irq, fault_reset, er;
   logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, sf = 1'b0, ce = 1'b1;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [15:0] st_req = 16'h0, pins_req = 16'h0, hs = 16'h0, ti = 16'h0;
   logic [15:0] st_l, pins_l, ac;
   logic [95:0] mt = 96'h0;
   int          bad_count = 0, tests_run = 0, frn = 0;

   sscw_top dut (.pclk(pclk), .presetn(presetn), .clk_en(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .st_running(st_l[0]), .st_all_enables(st_l[1]), .st_inching(st_l[2]),
      .st_initial_test(st_l[3]), .st_ramp_up(st_l[4]),
      .st_full_voltage(st_l[5]), .st_bypass_closed(st_l[6]),
      .st_ramp_down(st_l[7]), .st_braking(st_l[9]),
      .st_reversing(st_l[10]), .st_reverse(st_l[11]),
      .st_delay_before(st_l[12]), .st_delay_after(st_l[13]),
      .st_alarm(st_l[14]), .st_fault(st_l[15]),
      .input_pins_command_word(pins_l), .heatsink_temperature(hs),
      .thermal_image(ti), .motor_temperature(mt), .sensor_fitted(sf),
      .active_command(ac), .fault_reset(fault_reset), .irq(irq));
   sscw_far_side far (.pclk(pclk), .st_req(st_req), .pins_req(pins_req),
      .st_lines(st_l), .pins_lines(pins_l));

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   // count fault reset pulses as they happen
   always @(posedge pclk) if (fault_reset === 1'b1) frn <= frn + 1;

   task chk(input [31:0] g, input [31:0] e);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   // one apb transfer; request held until ready is sampled
   task apb(input w, input [11:0] a, input [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no fixed latency assumed; only the watchdog ends a hang
      do @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rdc(input [11:0] a, input [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask

   task t_status;
      rdc(`SSCW_OFF_ACTIVE_SRC, 32'h0);
      rdc(`SSCW_OFF_IRQ_MASK, 32'h0);
      for (int b = 0; b < 16; b++) begin
         if (b == 8) continue;
         st_req <= 16'h1 << b;
         repeat (8) @(posedge pclk);
         rdc(`SSCW_OFF_STATUS, 32'h1 << b);
      end
      st_req <= 16'h0;
      $display("status test done");
   endtask
   task t_cmd;
      // clock enable low must freeze the sync chain and the active word
      ce <= 1'b0;
      pins_req <= 16'hffff;
      repeat (8) @(posedge pclk);
      chk({16'h0, ac}, 32'h0);
      ce <= 1'b1;
      repeat (8) @(posedge pclk);
      rdc(`SSCW_OFF_CMD_BASE, 32'h39f);
      chk({16'h0, ac}, 32'h39f);
      rdc(`SSCW_OFF_STATUS, 32'h100);
      // walk the active source across all others
      for (int s = 1; s < 6; s++) begin
         apb(1'b1, `SSCW_OFF_ACTIVE_SRC, s);
         apb(1'b1, `SSCW_OFF_WRITE_CMD, 32'h13 + s);
         rdc(`SSCW_OFF_CMD_BASE + 12'(4 * s), 32'h13 + s);
         rdc(`SSCW_OFF_CMD_BASE + 12'(4 * s - 4), 32'h0);
      end
      apb(1'b1, `SSCW_OFF_ACTIVE_SRC, 32'h2);
      apb(1'b1, `SSCW_OFF_ACTIVE_SRC, 32'h6);
      rdc(`SSCW_OFF_ACTIVE_SRC, 32'h2);
      apb(1'b1, `SSCW_OFF_WRITE_CMD, 32'hffff);
      rdc(`SSCW_OFF_CMD_BASE + 12'h8, 32'h9f);
      chk(frn, 32'h0);
      apb(1'b0, 12'h04c, 32'h0);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
      $display("command test done");
   endtask
   task t_fault;
      apb(1'b1, `SSCW_OFF_IRQ_STAT, 32'h7);
      apb(1'b1, `SSCW_OFF_IRQ_MASK, 32'h1);
      apb(1'b1, `SSCW_OFF_WRITE_CMD, 32'h0);
      st_req <= 16'h8000;
      repeat (8) @(posedge pclk);
      apb(1'b1, `SSCW_OFF_WRITE_CMD, 32'h80);
      apb(1'b1, `SSCW_OFF_WRITE_CMD, 32'h80);
      repeat (4) @(posedge pclk);
      chk({irq, 31'(frn)}, {1'b1, 31'h1});
      rdc(`SSCW_OFF_IRQ_STAT, 32'h3);
      apb(1'b1, `SSCW_OFF_IRQ_STAT, 32'h1);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      rdc(`SSCW_OFF_IRQ_STAT, 32'h2);
      $display("fault test done");
   endtask
   // reset in mid-run returns outputs and settings to their reset values
   task t_reset;
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      chk({15'h0, irq, ac}, 32'h0);
      rdc(`SSCW_OFF_ACTIVE_SRC, 32'h0);
      rdc(`SSCW_OFF_IRQ_MASK, 32'h0);
      $display("reset test done");
   endtask
   task t_temp;
      hs <= 16'hffe0;
      ti <= 16'd1200;
      mt <= {16'd50, 16'd40, 16'd30, 16'd20, 16'hffe2, 16'd300};
      repeat (8) @(posedge pclk);
      rdc(`SSCW_OFF_HEATSINK, 32'hffffffea);
      rdc(`SSCW_OFF_THERMAL, 32'h3e8);
      rdc(`SSCW_OFF_MOTOR_BASE, 32'h0);
      sf <= 1'b1;
      repeat (8) @(posedge pclk);
      rdc(`SSCW_OFF_MOTOR_BASE, 32'h104);
      rdc(`SSCW_OFF_MOTOR_BASE + 12'h4, 32'hffffffec);
      for (int k = 2; k < 6; k++)
         rdc(`SSCW_OFF_MOTOR_BASE + 12'(4 * k), 32'(10 * k));
      $display("temperature test done");
   endtask

   task give_verdict;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // main sequence after 8 cycles of reset
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_status;
      t_cmd;
      t_fault;
      t_reset;
      t_temp;
      give_verdict;
   end
   // watchdog, well beyond the expected few hundred cycles
   initial begin
      repeat (20000) @(posedge pclk);
      bad_count++;
      give_verdict;
   end
endmodule // tb_top

bind sscw_top sscw_chk chk (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
   .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .active_command(active_command),
   .fault_reset(fault_reset));
